/* verilog/czcr_map.svh */
/*
 Register offsets, field positions, reset values and code tables of the
 charger zone configuration registers.
 Assumes it is included by its bare name wherever these names are needed.
*/
`ifndef CZCR_MAP_SVH
`define CZCR_MAP_SVH

// Register offsets on the management bus
`define CZCR_ZONE4_OFFSET      8'h08
`define CZCR_T40_OFFSET        8'h09
// Reset values
`define CZCR_ZONE4_RESET       8'hF3
`define CZCR_T40_RESET         8'hC0
// Field positions
`define CZCR_THR_MSB           7
`define CZCR_THR_LSB           5
`define CZCR_VSET_MSB          4
`define CZCR_VSET_LSB          3
`define CZCR_ISET_MSB          2
`define CZCR_ISET_LSB          0
`define CZCR_RSVD_BIT          7
`define CZCR_RECHG_BIT         6
`define CZCR_NOTERM_BIT        5
// Read-only reserved bit value
`define CZCR_RSVD_VALUE        1'h1
// Writable mask of the second register (bit 7 is read-only)
`define CZCR_T40_WMASK         8'h7F
// Threshold temperatures, degrees C
`define CZCR_TEMP_0C           8'h00
`define CZCR_TEMP_10C          8'h0A
`define CZCR_TEMP_15C          8'h0F
`define CZCR_TEMP_40C          8'h28
`define CZCR_TEMP_45C          8'h2D
`define CZCR_TEMP_50C          8'h32
// Termination feedback voltage, millivolts
`define CZCR_MV_2000           12'h7D0
`define CZCR_MV_2050           12'h802
`define CZCR_MV_2075           12'h81B
`define CZCR_MV_2100           12'h834
// Current fraction in eighths of the programmed current, 0 when off
`define CZCR_FRAC_EIGHTHS_BASE 4'h1
// Per mille of the programmed current in one eighth
`define CZCR_PM_PER_EIGHTH     14'h07D
// Value answered for an unmapped read offset
`define CZCR_RD_UNMAPPED       8'h00

`endif

/* verilog/czcr_pkg.sv */
/*
 Types shared by the charger zone configuration register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package czcr_pkg;

   // Decoded range setting handed to the charger state machine
   typedef struct packed {
      logic [11:0] term_mv;      // Termination feedback voltage, mV
      logic [9:0]  cur_permille; // Share of programmed current, per mille
   } czcr_range_t;

   // Threshold decode result
   typedef struct packed {
      logic       valid;         // Low when a reserved code is programmed
      logic [7:0] temp_c;        // Boundary temperature, degrees C
   } czcr_thresh_t;

endpackage : czcr_pkg

/* verilog/czcr_range_decode.sv */
/*
 Decodes one temperature range's voltage and current fraction fields.
 Assumes the fields come from registers on the same clock; purely
 combinational, the caller registers the result.
*/
`timescale 1ns/1ps
`include "czcr_map.svh"
module czcr_range_decode
   import czcr_pkg::*;
(
   // Raw fields
   input  wire logic [1:0]  vset,
   input  wire logic [2:0]  iset,
   // Decoded setting
   output czcr_range_t      range
);

   //////////////////////////////////////////////////////////////////////////
   // Voltage code to millivolts
   function automatic logic [11:0] czcr_vset_mv(input logic [1:0] code);
      unique case (code)
         2'h0: czcr_vset_mv = `CZCR_MV_2000;
         2'h1: czcr_vset_mv = `CZCR_MV_2050;
         2'h2: czcr_vset_mv = `CZCR_MV_2075;
         2'h3: czcr_vset_mv = `CZCR_MV_2100;
      endcase
   endfunction : czcr_vset_mv

   // Code n>0 gives (n+1)/8; 111 is unlisted and kept at 100 percent
   function automatic logic [9:0] czcr_iset_pm(input logic [2:0] code);
      logic [13:0] eighths;
      eighths = 14'(code) + 14'(`CZCR_FRAC_EIGHTHS_BASE);
      if (code == 3'h0)
         czcr_iset_pm = 10'h000;
      else
         czcr_iset_pm = 10'(eighths * `CZCR_PM_PER_EIGHTH);
   endfunction : czcr_iset_pm

   //////////////////////////////////////////////////////////////////////////
   // Shared mapping for both ranges
   assign range.term_mv      = czcr_vset_mv(vset);
   assign range.cur_permille = czcr_iset_pm(iset);

endmodule : czcr_range_decode

/* verilog/czcr_regs.sv */
/*
 Charger zone configuration register bank: two 8-bit registers written
 and read by the host through the device's serial management interface,
 with their fields decoded for the charger control state machine.
 Assumes the serial interface delivers one-cycle write strobes and a
 read address on ref_clk; the read path answers the next cycle.
*/
`timescale 1ns/1ps
`include "czcr_map.svh"
module czcr_regs
   import czcr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Register access from the serial interface
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   output logic      [7:0]  rd_data,
   output logic             rd_hit,
   // Events from the charger analog front end
   input  wire logic        low_batt_voltage,
   input  wire logic        low_charge_current,
   // Decoded configuration to the charger state machine
   output czcr_thresh_t     upper_warm_threshold,
   output czcr_range_t      warm_range,
   output czcr_range_t      hot_range,
   output logic             auto_recharge_enable,
   output logic             low_current_termination_disable,
   // Charger actions
   output logic             recharge_start,
   output logic             charge_terminate
);

   //////////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0]   zone4_r;     // Threshold and warm-range setting
   logic [7:0]   t40_r;       // Hot-range setting and charge controls
   logic [1:0]   lbv_sync_r;  // Low battery voltage synchroniser
   logic [1:0]   lcc_sync_r;  // Low charge current synchroniser
   logic         zone4_wr;    // Host writes the first register
   logic         t40_wr;      // Host writes the second register
   logic [7:0]   t40_nxt;     // Second register after a masked write
   logic [7:0]   rd_data_nxt; // Read mux output
   logic         rd_hit_nxt;  // Read of a mapped offset
   czcr_range_t  warm_nxt;    // Decoded warm-range setting
   czcr_range_t  hot_nxt;     // Decoded hot-range setting
   czcr_thresh_t thresh_nxt;  // Decoded threshold

   // Offset compare, shared by the write and the read decoders
   function automatic logic czcr_addr_match(input logic [7:0] addr, input logic [7:0] offset);
      czcr_addr_match = (addr == offset);
   endfunction : czcr_addr_match

   // Threshold code to temperature; reserved codes flagged invalid
   function automatic czcr_thresh_t czcr_thr_decode(input logic [2:0] code);
      czcr_thr_decode.valid = 1'b1;
      unique case (code)
         3'h1:    czcr_thr_decode.temp_c = `CZCR_TEMP_0C;
         3'h2:    czcr_thr_decode.temp_c = `CZCR_TEMP_10C;
         3'h3:    czcr_thr_decode.temp_c = `CZCR_TEMP_15C;
         3'h4:    czcr_thr_decode.temp_c = `CZCR_TEMP_40C;
         3'h5:    czcr_thr_decode.temp_c = `CZCR_TEMP_45C;
         3'h6:    czcr_thr_decode.temp_c = `CZCR_TEMP_50C;
         default: begin
            czcr_thr_decode.valid  = 1'b0;
            czcr_thr_decode.temp_c = `CZCR_TEMP_0C;
         end
      endcase
   endfunction : czcr_thr_decode

   //////////////////////////////////////////////////////////////////////////
   // Write decode; a write to any other offset is dropped silently
   assign zone4_wr = wr_en && czcr_addr_match(wr_addr, `CZCR_ZONE4_OFFSET);
   assign t40_wr   = wr_en && czcr_addr_match(wr_addr, `CZCR_T40_OFFSET);

   // Reserved bit 7 keeps its value whatever the host writes
   assign t40_nxt = (t40_r & ~`CZCR_T40_WMASK) | (wr_data & `CZCR_T40_WMASK);

   // First register: every bit writable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         zone4_r <= `CZCR_ZONE4_RESET;
      end else if (zone4_wr) begin
         zone4_r <= wr_data;
      end
   end

   // Second register: masked so the reserved bit cannot be cleared
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         t40_r <= `CZCR_T40_RESET;
      end else if (t40_wr) begin
         t40_r <= t40_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read mux; a read in the cycle of a write still sees the old value
   always_comb begin
      rd_data_nxt = `CZCR_RD_UNMAPPED;
      if (czcr_addr_match(rd_addr, `CZCR_ZONE4_OFFSET)) begin
         rd_data_nxt = zone4_r;
      end else if (czcr_addr_match(rd_addr, `CZCR_T40_OFFSET)) begin
         rd_data_nxt = {`CZCR_RSVD_VALUE, t40_r[`CZCR_RSVD_BIT-1:0]};
      end
   end

   assign rd_hit_nxt = rd_en && (czcr_addr_match(rd_addr, `CZCR_ZONE4_OFFSET) ||
                                 czcr_addr_match(rd_addr, `CZCR_T40_OFFSET));

   // Read data holds until the next read so a slow host can fetch it late
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= `CZCR_RD_UNMAPPED;
      end else if (rd_en) begin
         rd_data <= rd_data_nxt;
      end
   end

   // Hit flag is a one-cycle pulse after each mapped read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_hit <= 1'b0;
      end else begin
         rd_hit <= rd_hit_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Shared range decoders
   czcr_range_decode u_warm (
      .vset  (zone4_r[`CZCR_VSET_MSB:`CZCR_VSET_LSB]),
      .iset  (zone4_r[`CZCR_ISET_MSB:`CZCR_ISET_LSB]),
      .range (warm_nxt)
   );

   czcr_range_decode u_hot (
      .vset  (t40_r[`CZCR_VSET_MSB:`CZCR_VSET_LSB]),
      .iset  (t40_r[`CZCR_ISET_MSB:`CZCR_ISET_LSB]),
      .range (hot_nxt)
   );

   // Threshold decode; reserved codes give an invalid flag, not a guess
   assign thresh_nxt = czcr_thr_decode(zone4_r[`CZCR_THR_MSB:`CZCR_THR_LSB]);

   //////////////////////////////////////////////////////////////////////////
   // Decoded outputs registered so the state machine sees clean levels;
   // they trail a register write by one cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         upper_warm_threshold <= '0;
      end else begin
         upper_warm_threshold <= thresh_nxt;
      end
   end

   // Warm-range setting
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         warm_range <= '0;
      end else begin
         warm_range <= warm_nxt;
      end
   end

   // Hot-range setting
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hot_range <= '0;
      end else begin
         hot_range <= hot_nxt;
      end
   end

   // Recharge enable copy for the state machine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_recharge_enable <= 1'b0;
      end else begin
         auto_recharge_enable <= t40_r[`CZCR_RECHG_BIT];
      end
   end

   // Termination disable copy for the state machine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_current_termination_disable <= 1'b0;
      end else begin
         low_current_termination_disable <= t40_r[`CZCR_NOTERM_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Analog comparator outputs are asynchronous; two flops before use
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lbv_sync_r <= '0;
      end else begin
         lbv_sync_r <= {lbv_sync_r[0], low_batt_voltage};
      end
   end

   // Second comparator has its own synchroniser; no shared flops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lcc_sync_r <= '0;
      end else begin
         lcc_sync_r <= {lcc_sync_r[0], low_charge_current};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Level requests to the charger; it acts on them as long as they stand.
   // The control bits are taken straight from the register so a change of
   // setting acts one cycle sooner than a comparator event
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         recharge_start <= 1'b0;
      end else begin
         recharge_start <= lbv_sync_r[1] & t40_r[`CZCR_RECHG_BIT];
      end
   end

   // Termination request, masked while current-based termination is off
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         charge_terminate <= 1'b0;
      end else begin
         charge_terminate <= lcc_sync_r[1] & ~t40_r[`CZCR_NOTERM_BIT];
      end
   end

endmodule : czcr_regs

/* testbench/czcr_host.sv */
/*
 Host model for the charger zone register bank: single writes and reads.
 Assumes the bank samples requests on the rising edge of ref_clk.
*/
`timescale 1ns/1ps
module czcr_host (
   // Clock and read answer
   input  wire logic       ref_clk,
   input  wire logic       rd_hit,
   input  wire logic [7:0] rd_data,
   // Requests
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] wr_addr,
   output logic      [7:0] wr_data,
   output logic      [7:0] rd_addr
);
   initial {wr_en, rd_en, wr_addr, wr_data, rd_addr} = '0;
   // Long idle gap so each write settles alone
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      {wr_en, wr_addr, wr_data} = {1'b1, a, d};
      @(negedge ref_clk);
      {wr_en, wr_addr, wr_data} = {1'b0, ~a, ~d}; // Released bus shows no stale value
      repeat (3) @(negedge ref_clk);
   endtask : wr
   // Answer looked for within three cycles
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(negedge ref_clk);
      {rd_en, rd_addr} = {1'b1, a};
      @(negedge ref_clk);
      {rd_en, rd_addr} = {1'b0, ~a};
      h = 1'b0;
      for (int k = 0; k < 3; k++) begin
         h |= rd_hit;
         @(negedge ref_clk);
      end
      d = rd_data;
   endtask : rd
endmodule : czcr_host

/* testbench/czcr_regs_properties.sv */
/*
 Port assertions of the charger zone register bank.
 Assumes it is bound to czcr_regs; writes are at least four cycles apart.
*/
`timescale 1ns/1ps
module czcr_regs_properties
   import czcr_pkg::*;
(
   // Clock, reset and writes
   input wire logic       ref_clk, rst_n, wr_en,
   input wire logic [7:0] wr_addr, wr_data,
   // Charger side
   input wire logic       low_batt_voltage,
   input wire logic       low_charge_current, auto_recharge_enable, low_current_termination_disable,
   input wire logic       recharge_start, charge_terminate,
   input czcr_thresh_t    upper_warm_threshold,
   input czcr_range_t     warm_range, hot_range
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Write decodes per register
   logic w8, w9;
   assign w8 = wr_en && wr_addr == 8'h08;
   assign w9 = wr_en && wr_addr == 8'h09;
   property p_thr; w8 && wr_data[7:5] == 3'h4 |-> ##3 upper_warm_threshold == 9'h128; endproperty
   a_thr: assert property (p_thr) else $error("threshold decode wrong");
   property p_rsv; w8 && wr_data[7:5] inside {3'h0, 3'h7} |-> ##3 !upper_warm_threshold.valid; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved code not flagged");
   property p_wv; w8 && wr_data[4:3] == 2'h3 |-> ##3 warm_range.term_mv == 12'h834; endproperty
   a_wv: assert property (p_wv) else $error("warm voltage wrong");
   property p_wi; w8 && wr_data[2:0] == 3'h1 |-> ##3 warm_range.cur_permille == 10'h0FA; endproperty
   a_wi: assert property (p_wi) else $error("warm fraction wrong");
   property p_hv; w9 && wr_data[4:3] == 2'h2 |-> ##3 hot_range.term_mv == 12'h81B; endproperty
   a_hv: assert property (p_hv) else $error("hot voltage wrong");
   property p_hi; w9 && wr_data[2:0] == 3'h0 |-> ##3 hot_range.cur_permille == 10'h000; endproperty
   a_hi: assert property (p_hi) else $error("hot fraction wrong");
   property p_rc; recharge_start |-> auto_recharge_enable; endproperty
   a_rc: assert property (p_rc) else $error("recharge while disabled");
   property p_re; (low_batt_voltage && auto_recharge_enable) [*4] |=> recharge_start; endproperty
   a_re: assert property (p_re) else $error("no recharge on low battery");
   property p_te; (low_charge_current && !low_current_termination_disable) [*4] |=> charge_terminate; endproperty
   a_te: assert property (p_te) else $error("no termination on low current");
   property p_nt; charge_terminate |-> !low_current_termination_disable; endproperty
   a_nt: assert property (p_nt) else $error("terminated while disabled");
endmodule : czcr_regs_properties
bind czcr_regs czcr_regs_properties u_czcr_regs_properties (.*);

/* testbench/tb.sv */
/*
 Self-checking bench of the charger zone register bank.
 Assumes the host model and checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb;
   import czcr_pkg::*;
   logic         ref_clk = 0, rst_n = 0, low_batt_voltage = 0, low_charge_current = 0;
   logic         wr_en, rd_en, rd_hit, auto_recharge_enable, low_current_termination_disable;
   logic         recharge_start, charge_terminate;
   logic [7:0]   wr_addr, wr_data, rd_addr, rd_data;
   czcr_thresh_t upper_warm_threshold;
   czcr_range_t  warm_range, hot_range;
   int           errors = 0, compares = 0;
   logic [11:0]  mv [4] = '{12'h7D0, 12'h802, 12'h81B, 12'h834};
   logic [7:0]   tc [8] = '{8'h00, 8'h00, 8'h0A, 8'h0F, 8'h28, 8'h2D, 8'h32, 8'h00};
   // Eighths of programmed current in per mille; 111 is kept at the full current
   logic [9:0]   pm [8] = '{10'h000, 10'h0FA, 10'h177, 10'h1F4, 10'h271, 10'h2EE, 10'h36B, 10'h3E8};
   always #4 ref_clk = ~ref_clk;
   czcr_host u_czcr_host (.*);
   czcr_regs u_czcr_regs (.*);
   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   // A missing answer ends the run at once
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic h);
      logic [7:0] d;
      logic       hit;
      u_czcr_host.rd(a, d, hit);
      `CHK("rd_data", e, d)
      `CHK("rd_hit", h, hit)
      if (hit !== h) report_and_stop;
   endtask : rd_chk
   task automatic t_reset;
      rd_chk(8'h08, 8'hF3, 1'b1);
      rd_chk(8'h09, 8'hC0, 1'b1);
      rd_chk(8'h0A, 8'h00, 1'b0);
      `CHK("warm", {12'h81B, 10'h1F4}, warm_range)
      `CHK("hot", {12'h7D0, 10'h000}, hot_range)
      $display("t_reset done");
   endtask : t_reset
   // Reset in mid-run returns both registers, hot range, threshold, rd_hit, both requests and auto_recharge_enable to defaults
   task automatic t_rerst;
      u_czcr_host.wr(8'h08, 8'h00);
      u_czcr_host.wr(8'h09, 8'h3F);
      `CHK("hot7", {12'h834, 10'h3E8}, hot_range)
      `CHK("flags1", 2'h1, {auto_recharge_enable, low_current_termination_disable})
      @(negedge ref_clk) rst_n = 1'b0;
      @(negedge ref_clk);
      `CHK("rst_out", 4'h0, {rd_hit, recharge_start, charge_terminate, auto_recharge_enable})
      `CHK("rst_thr", 9'h000, upper_warm_threshold)
      `CHK("rst_hot", 22'h000000, hot_range)
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      rd_chk(8'h08, 8'hF3, 1'b1);
      rd_chk(8'h09, 8'hC0, 1'b1);
      `CHK("warm_rst", {12'h81B, 10'h1F4}, warm_range)
      `CHK("flags_rst", 2'h2, {auto_recharge_enable, low_current_termination_disable})
      $display("t_rerst done");
   endtask : t_rerst
   task automatic t_thresh;
      for (int c = 0; c < 8; c++) begin
         u_czcr_host.wr(8'h08, {c[2:0], 5'h00});
         `CHK("thr", {c != 0 && c != 7, tc[c]}, upper_warm_threshold)
      end
      u_czcr_host.wr(8'h0C, 8'h00);
      rd_chk(8'h08, 8'hE0, 1'b1);
      $display("t_thresh done");
   endtask : t_thresh
   task automatic t_range;
      for (int i = 0; i < 8; i++) begin
         u_czcr_host.wr(8'h08, {3'h1, i[1:0], i[2:0]});
         u_czcr_host.wr(8'h09, {3'h0, i[1:0], ~i[2:0]});
         `CHK("warm", {mv[i[1:0]], pm[i[2:0]]}, warm_range)
         `CHK("hot", {mv[i[1:0]], pm[~i[2:0]]}, hot_range)
         rd_chk(8'h09, {3'h4, i[1:0], ~i[2:0]}, 1'b1);
      end
      $display("t_range done");
   endtask : t_range
   // Both front-end events raised under every control bit pair
   task automatic t_ctl;
      for (int k = 0; k < 4; k++) begin
         u_czcr_host.wr(8'h09, {1'b0, k[1:0], 5'h00});
         @(negedge ref_clk) {low_batt_voltage, low_charge_current} = 2'h3;
         repeat (5) @(negedge ref_clk);
         `CHK("rechg", k[1], recharge_start)
         `CHK("term", ~k[0], charge_terminate)
         `CHK("flags", k[1:0], {auto_recharge_enable, low_current_termination_disable})
         @(negedge ref_clk) {low_batt_voltage, low_charge_current} = 2'h0;
         repeat (5) @(negedge ref_clk);
         `CHK("idle", 2'h0, {recharge_start, charge_terminate})
      end
      $display("t_ctl done");
   endtask : t_ctl
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_n = 1;
      t_reset;
      t_thresh;
      t_range;
      t_ctl;
      t_rerst;
      report_and_stop;
   end
endmodule : tb
